/* dsc_pkg.sv */
// shared constants for the serial command decoder
package dsc_pkg;
	localparam int          WORD_W     = 16;
	localparam int          CODE_W     = 4;
	localparam int          DATA_W     = 12;
	localparam int          CODE_LSB   = 12;
	localparam int          CNT_W      = 5;
	localparam logic [4:0]  WORD_BITS  = 5'h10;
	localparam logic [3:0]  CMD_NOP    = 4'h0;
	localparam logic [3:0]  CMD_LOAD   = 4'h1;
	localparam logic [3:0]  CMD_RDBK   = 4'h2;
	localparam logic [3:0]  CMD_NOCHN  = 4'h9;
	localparam logic [3:0]  CMD_RISE   = 4'ha;
	localparam logic [3:0]  CMD_ZERO   = 4'hb;
	localparam logic [3:0]  CMD_MID    = 4'hc;
	localparam logic [11:0] ZERO_CODE  = 12'h000;
	localparam logic [11:0] MID_CODE   = 12'h800;
	localparam logic        RST_DAISY  = 1'b1;
	localparam logic        RST_RISE   = 1'b0;
	localparam int          SYNC_STAGE = 2;
endpackage

/* dsc_link.sv */
// serial-clock side: shift register, bit count, chain and readback output
`timescale 1ns/100ps
module dsc_link (
	input  wire logic        link_clk,     // serial clock from the host
	input  wire logic        frame_n,      // frame select, low while a word is shifted
	input  wire logic        serial_input, // serial data in
	input  wire logic        rise_mode,    // sys-domain level: capture on rising edges
	input  wire logic        alone_mode,   // sys-domain level: stand-alone operation
	input  wire logic        rb_req,       // sys-domain level: readback pending for the next frame
	input  wire logic [11:0] rb_word,      // converter register, stable while requested
	output logic      [15:0] word_f,       // falling-edge shift register
	output logic      [15:0] word_r,       // rising-edge shift register
	output logic      [15:0] hold_f,       // word caught at 16th falling edge
	output logic      [15:0] hold_r,       // word caught at 16th rising edge
	output logic             done_f,       // high from 16th falling edge to frame rise, stand-alone
	output logic             done_r,       // high from 16th rising edge to frame rise, stand-alone
	output logic             sdo_q         // serial output bit
);
	// ----------------------------------------
	// mode synchronisers
	// ----------------------------------------
	logic [2:0] s1_q, s2_q;
	logic       rise_s, alone_s, rbreq_s;
	always_ff @(posedge link_clk) begin
		s1_q <= {rise_mode, alone_mode, rb_req};
		s2_q <= s1_q;
	end
	assign {rise_s, alone_s, rbreq_s} = s2_q;

	function automatic logic [15:0] shl(input logic [15:0] v, input logic b);
		shl = {v[14:0], b};
	endfunction

	// ----------------------------------------
	// falling-edge capture
	// ----------------------------------------
	logic [4:0]  cnt_f_q, cnt_f_d;
	logic [15:0] sh_f_d, hf_d;
	logic        df_d;
	always_comb begin
		cnt_f_d = cnt_f_q;
		sh_f_d  = word_f;
		hf_d    = hold_f;
		df_d    = done_f;
		if (!rise_s && cnt_f_q < dsc_pkg::WORD_BITS) begin
			sh_f_d  = shl(word_f, serial_input);
			cnt_f_d = cnt_f_q + 5'h01;
			if (alone_s && cnt_f_d == dsc_pkg::WORD_BITS) begin
				hf_d = sh_f_d;
				df_d = 1'b1;
			end
		end else if (!rise_s && !alone_s) begin
			sh_f_d = shl(word_f, serial_input); // chain keeps shifting past 16
		end
	end
	// frame high clears count and done level: stand-alone, an early rise discards the word
	// link side has no reset, so this clear is also what gives done a known value
	always_ff @(negedge link_clk or posedge frame_n) begin
		if (frame_n) begin
			cnt_f_q <= 5'h00;
			done_f  <= 1'b0;
		end else begin
			cnt_f_q <= cnt_f_d;
			done_f  <= df_d;
		end
	end
	always_ff @(negedge link_clk) begin
		word_f <= frame_n ? word_f : sh_f_d;
		hold_f <= frame_n ? hold_f : hf_d;
	end

	// ----------------------------------------
	// rising-edge capture
	// ----------------------------------------
	logic [4:0]  cnt_r_q, cnt_r_d;
	logic [15:0] sh_r_d, hr_d;
	logic        dr_d;
	always_comb begin
		cnt_r_d = cnt_r_q;
		sh_r_d  = word_r;
		hr_d    = hold_r;
		dr_d    = done_r;
		if (rise_s && cnt_r_q < dsc_pkg::WORD_BITS) begin
			sh_r_d  = shl(word_r, serial_input);
			cnt_r_d = cnt_r_q + 5'h01;
			if (alone_s && cnt_r_d == dsc_pkg::WORD_BITS) begin
				hr_d = sh_r_d;
				dr_d = 1'b1;
			end
		end else if (rise_s && !alone_s) begin
			sh_r_d = shl(word_r, serial_input);
		end
	end

	// ----------------------------------------
	// output: chain bit or readback word
	// ----------------------------------------
	logic [15:0] rb_sh_q, rb_sh_d, rb_full;
	logic [4:0]  rb_cnt_q, rb_cnt_d;
	logic        first_q;
	logic        sdo_d;
	assign rb_full = {4'h0, rb_word};
	always_comb begin
		rb_sh_d  = shl(rb_sh_q, 1'b0);
		rb_cnt_d = (rb_cnt_q != 5'h00) ? rb_cnt_q - 5'h01 : 5'h00;
		sdo_d    = rise_s ? word_r[15] : word_f[15];
		if (rb_cnt_q != 5'h00) begin
			sdo_d = rb_sh_q[15];
		end
		// readback fills the next frame from its first rising edge; rb_word is quasi-static then
		if (!first_q && rbreq_s) begin
			sdo_d    = rb_full[15];
			rb_sh_d  = shl(rb_full, 1'b0);
			rb_cnt_d = dsc_pkg::WORD_BITS - 5'h01;
		end
	end
	always_ff @(posedge link_clk or posedge frame_n) begin
		if (frame_n) begin
			cnt_r_q  <= 5'h00;
			done_r   <= 1'b0;
			rb_cnt_q <= 5'h00;
			first_q  <= 1'b0;
		end else begin
			cnt_r_q  <= cnt_r_d;
			done_r   <= dr_d;
			rb_cnt_q <= rb_cnt_d;
			first_q  <= 1'b1;
		end
	end
	always_ff @(posedge link_clk) begin
		word_r  <= frame_n ? word_r : sh_r_d;
		hold_r  <= frame_n ? hold_r : hr_d;
		rb_sh_q <= rb_sh_d;
		sdo_q   <= sdo_d;
	end

	initial begin
		if (dsc_pkg::WORD_W != dsc_pkg::CODE_W + dsc_pkg::DATA_W) begin
			$error("word width mismatch");
		end
	end
endmodule

/* dsc_decoder.sv */
// serial command decoder for a 12-bit converter register
// How it works
// - A 16-bit shift register holds a 4-bit control code on top of 12 data bits.
// - The decoded function runs at frame rise in daisy-chain mode and at the 16th active edge stand-alone.
// - Code 0001 loads the 12 data bits into the converter register; no other code uses them.
// - Stand-alone, a frame rise before the 16th edge discards the word with no update or mode change.
// - After reset serial bits are captured on falling clock edges.
// - After reset the block is in daisy-chain mode with the chain output enabled.
// - Reset loads zero-scale into the converter register.
// - Code 0000 does nothing and is the reset default.
// - Code 0010 starts a readback of the converter register on the serial output.
// - Code 1001 leaves daisy-chain mode for stand-alone operation.
// - Code 1010 moves capture to rising clock edges.
// - Code 1011 clears the converter register to zero-scale.
// - Code 1100 clears the converter register to midscale, top data bit alone set.
`timescale 1ns/100ps
module dsc_decoder (
	input  wire logic        sys_clk,            // system clock, 125 MHz
	input  wire logic        rstn,               // synchronous reset, active low
	input  wire logic        link_clk,           // serial clock from the host
	input  wire logic        frame_n,            // frame select, active low
	input  wire logic        serial_input,       // serial data in
	output logic             serial_output,      // chain or readback data out
	output logic             serial_output_oe_n, // low while serial_output is driven
	output logic [11:0]      current_output,     // converter register code
	output logic             daisy_mode,         // high in daisy-chain mode
	output logic             rise_edge_mode,     // high when capturing on rising edges
	output logic             cmd_done            // one-cycle pulse per executed word
);
	// ----------------------------------------
	// link side
	// ----------------------------------------
	logic [15:0] word_f, word_r, hold_f, hold_r;
	logic        done_f, done_r, sdo_l;
	logic        daisy_q, daisy_d, rise_q, rise_d, rbt_q, rbt_d;
	logic [11:0] dac_q, dac_d;
	logic        rb_busy_q, rb_busy_d, rb_open_q, rb_open_d;

	dsc_link u_link (
		.link_clk     (link_clk),
		.frame_n      (frame_n),
		.serial_input (serial_input),
		.rise_mode    (rise_q),
		.alone_mode   (~daisy_q),
		.rb_req       (rb_busy_q),
		.rb_word      (dac_q),
		.word_f       (word_f),
		.word_r       (word_r),
		.hold_f       (hold_f),
		.hold_r       (hold_r),
		.done_f       (done_f),
		.done_r       (done_r),
		.sdo_q        (sdo_l)
	);

	// ----------------------------------------
	// synchronisers into sys_clk
	// ----------------------------------------
	logic [3:0] m1_q, m2_q;
	logic [2:0] last_q;
	always_ff @(posedge sys_clk) begin
		m1_q <= {frame_n, done_f, done_r, sdo_l};
		m2_q <= m1_q;
	end
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			last_q <= 3'b100;
		end else begin
			last_q <= m2_q[3:1];
		end
	end

	logic frame_rise, frame_fall, ev_f, ev_r;
	assign frame_rise = m2_q[3] & ~last_q[2];
	assign frame_fall = ~m2_q[3] & last_q[2];
	// done levels stand until frame rise, so only their rising edge counts
	assign ev_f       = m2_q[2] & ~last_q[1];
	assign ev_r       = m2_q[1] & ~last_q[0];

	// ----------------------------------------
	// command execution
	// ----------------------------------------
	logic        exec;
	logic [15:0] word;
	logic [3:0]  code;
	logic        done_d;
	always_comb begin
		exec = 1'b0;
		word = 16'h0000;
		// words are stable: the link stops shifting once frame is high, and stand-alone also once 16 bits are in
		if (daisy_q && frame_rise) begin
			exec = 1'b1;
			word = rise_q ? word_r : word_f;
		end else if (!daisy_q && ev_f) begin
			exec = 1'b1;
			word = hold_f;
		end else if (!daisy_q && ev_r) begin
			exec = 1'b1;
			word = hold_r;
		end
		code    = word[dsc_pkg::CODE_LSB +: dsc_pkg::CODE_W];
		dac_d   = dac_q;
		daisy_d = daisy_q;
		rise_d  = rise_q;
		rbt_d   = rbt_q;
		if (exec) begin
			case (code)
				dsc_pkg::CMD_LOAD:  dac_d   = word[dsc_pkg::DATA_W-1:0];
				dsc_pkg::CMD_RDBK:  rbt_d   = ~rbt_q;
				dsc_pkg::CMD_NOCHN: daisy_d = 1'b0;
				dsc_pkg::CMD_RISE:  rise_d  = 1'b1;
				dsc_pkg::CMD_ZERO:  dac_d   = dsc_pkg::ZERO_CODE;
				dsc_pkg::CMD_MID:   dac_d   = dsc_pkg::MID_CODE;
				default:            dac_d   = dac_q;
			endcase
		end
		done_d = exec;
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			dac_q    <= dsc_pkg::ZERO_CODE;
			daisy_q  <= dsc_pkg::RST_DAISY;
			rise_q   <= dsc_pkg::RST_RISE;
			rbt_q    <= 1'b0;
			cmd_done <= 1'b0;
		end else begin
			dac_q    <= dac_d;
			daisy_q  <= daisy_d;
			rise_q   <= rise_d;
			rbt_q    <= rbt_d;
			cmd_done <= done_d;
		end
	end

	// ----------------------------------------
	// outputs, all registered
	// ----------------------------------------
	// busy spans the whole next frame; stand-alone, the command's own frame ends after it
	always_comb begin
		rb_busy_d = rb_busy_q;
		rb_open_d = rb_open_q;
		if (rbt_d != rbt_q) begin
			rb_busy_d = 1'b1;
			rb_open_d = 1'b0;
		end else if (rb_busy_q && frame_fall) begin
			rb_open_d = 1'b1;
		end else if (rb_open_q && frame_rise) begin
			rb_busy_d = 1'b0;
			rb_open_d = 1'b0;
		end
	end
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			rb_busy_q          <= 1'b0;
			rb_open_q          <= 1'b0;
			serial_output      <= 1'b0;
			serial_output_oe_n <= 1'b0;
			current_output     <= dsc_pkg::ZERO_CODE;
			daisy_mode         <= dsc_pkg::RST_DAISY;
			rise_edge_mode     <= dsc_pkg::RST_RISE;
		end else begin
			rb_busy_q          <= rb_busy_d;
			rb_open_q          <= rb_open_d;
			serial_output      <= m2_q[0];
			serial_output_oe_n <= ~(daisy_q | rb_busy_q);
			current_output     <= dac_q;
			daisy_mode         <= daisy_q;
			rise_edge_mode     <= rise_q;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	load_path_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		exec && code == dsc_pkg::CMD_LOAD |-> ##1 dac_q == $past(word[11:0]) ##1 current_output == $past(dac_q))
		else $error("load did not reach the converter register");
	mid_clear_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		exec && code == dsc_pkg::CMD_MID |-> ##2 current_output == 12'h800)
		else $error("midscale clear wrong");
	zero_clear_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		exec && code == dsc_pkg::CMD_ZERO |-> ##2 current_output == 12'h000)
		else $error("zero clear wrong");
	idle_hold_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		!exec || code == dsc_pkg::CMD_NOP || (code > dsc_pkg::CMD_RDBK && code < dsc_pkg::CMD_NOCHN)
		|=> $stable(dac_q) && $stable(daisy_q) && $stable(rise_q))
		else $error("state changed without a command");
	chain_off_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		$fell(daisy_q) |-> $past(exec) && $past(code) == dsc_pkg::CMD_NOCHN)
		else $error("chain mode left without command");
	mode_keep_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		!daisy_q |=> !daisy_q ##1 !daisy_q)
		else $error("stand-alone mode lost");
	edge_keep_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		$rose(rise_q) |-> $past(code) == dsc_pkg::CMD_RISE ##1 rise_q [*3])
		else $error("edge mode changed wrongly");
	exec_when_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		exec |-> (daisy_q && frame_rise) || (!daisy_q && (ev_f || ev_r)))
		else $error("command executed at the wrong moment");
	reset_val_a: assert property (@(posedge sys_clk)
		!rstn |=> dac_q == 12'h000 && daisy_q && !rise_q)
		else $error("reset defaults wrong");
	readback_a: assert property (@(posedge sys_clk) disable iff (!rstn)
		exec && code == dsc_pkg::CMD_RDBK |=> rbt_q != $past(rbt_q) ##1 rb_busy_q)
		else $error("readback not started");
endmodule

/* dsc_host.sv */
// serial host model: frames words onto the link and collects returned bits
`timescale 1ns/100ps
module dsc_host (
	output logic      link_clk,     // serial clock, idles high, two idle cycles before each frame
	output logic      frame_n,      // frame select, low while a word is shifted
	output logic      serial_input, // data to the decoder
	input  wire logic serial_output // chain or readback bit
);
	logic [31:0] rx; // one sample after each in-frame rising edge

	initial begin
		link_clk = 1'b1;
		frame_n = 1'b1;
		serial_input = 1'b0;
		rx = 32'h0000_0000;
	end

	// ----------------------------------------
	// one frame of n bits of w
	// ----------------------------------------
	task automatic send(input logic [31:0] w, input int n);
		// edges with the frame high are ignored but carry mode changes to the link side
		repeat (2) begin
			#62.5 link_clk = 1'b0;
			#62.5 link_clk = 1'b1;
		end
		// frame falls off the clock edge, so the last idle edge never counts as a bit
		#31.25 frame_n = 1'b0;
		for (int i = n - 1; i >= 0; i--) begin
			// data moves a quarter period off both edges so either capture edge is clean
			#31.25 serial_input = w[i];
			#31.25;
			if (i < n - 1) rx = {rx[30:0], serial_output};
			link_clk = 1'b0;
			#62.5 link_clk = 1'b1;
		end
		#62.5 rx = {rx[30:0], serial_output};
		frame_n = 1'b1;
		serial_input = ~serial_input; // released line must not look held
	endtask
endmodule

/* dsc_decoder_tb.sv */
// self-checking bench for the serial command decoder
`timescale 1ns/100ps
module dsc_decoder_tb;
	logic        sys_clk;
	logic        rstn;
	logic        link_clk;
	logic        frame_n;
	logic        serial_input;
	logic        serial_output;
	logic        serial_output_oe_n;
	logic [11:0] current_output;
	logic        daisy_mode;
	logic        rise_edge_mode;
	logic        cmd_done;
	logic        done_frame = 1'bx; // frame select level at the last done pulse
	int          done_cnt;
	int          cnt0;
	int          errors;
	int          compares;

	dsc_host host (
		.link_clk     (link_clk),
		.frame_n      (frame_n),
		.serial_input (serial_input),
		.serial_output(serial_output)
	);

	dsc_decoder DUT (
		.sys_clk           (sys_clk),
		.rstn              (rstn),
		.link_clk          (link_clk),
		.frame_n           (frame_n),
		.serial_input      (serial_input),
		.serial_output     (serial_output),
		.serial_output_oe_n(serial_output_oe_n),
		.current_output    (current_output),
		.daisy_mode        (daisy_mode),
		.rise_edge_mode    (rise_edge_mode),
		.cmd_done          (cmd_done)
	);

	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end

	always @(posedge sys_clk) begin
		if (cmd_done === 1'b1) begin
			done_frame <= frame_n;
			done_cnt <= done_cnt + 1;
		end
	end

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic state(input logic [11:0] co, input logic dm, input logic rm);
		chk("current_output", {4'h0, current_output}, {4'h0, co});
		chk("daisy_mode", {15'h0, daisy_mode}, {15'h0, dm});
		chk("rise_edge_mode", {15'h0, rise_edge_mode}, {15'h0, rm});
	endtask

	// the settle wait covers the done pulse plus the register update
	task automatic word(input logic [31:0] w, input int n);
		host.send(w, n);
		repeat (10) @(posedge sys_clk);
	endtask

	task automatic do_reset();
		rstn <= 1'b0;
		repeat (16) @(posedge sys_clk);
		rstn <= 1'b1;
		repeat (4) @(posedge sys_clk);
	endtask

	task automatic print_verdict();
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// ----------------------------------------
	// sequence
	// ----------------------------------------
	initial begin
		rstn = 1'b0;
		do_reset();
		state(12'h000, 1'b1, 1'b0);
		chk("oe_n", {15'h0, serial_output_oe_n}, 16'h0000);
		word(32'h1abc_1123, 32);
		state(12'h123, 1'b1, 1'b0);
		chk("chain", host.rx[16:1], 16'h1abc);
		chk("done_frame", {15'h0, done_frame}, 16'h0001);
		word(32'h0000_0fff, 16);
		state(12'h123, 1'b1, 1'b0);
		word(32'h0000_b5a5, 16);
		state(12'h000, 1'b1, 1'b0);
		word(32'h0000_c5a5, 16);
		state(12'h800, 1'b1, 1'b0);
		for (int c = 3; c < 16; c++) begin
			if (c < 9 || c > 12) begin
				word({16'h0000, 4'(c), 12'h3c3}, 16);
				state(12'h800, 1'b1, 1'b0);
			end
		end
		word(32'h0000_9000, 16);
		state(12'h800, 1'b0, 1'b0);
		chk("oe_n", {15'h0, serial_output_oe_n}, 16'h0001);
		word(32'h0000_1456, 16);
		state(12'h456, 1'b0, 1'b0);
		chk("done_frame", {15'h0, done_frame}, 16'h0000);
		// one edge short of a word must leave no trace
		cnt0 = done_cnt;
		word(32'h0000_0bbb, 15);
		state(12'h456, 1'b0, 1'b0);
		chk("done_cnt", 16'(done_cnt), 16'(cnt0));
		word(32'h0000_2000, 16);
		chk("oe_n", {15'h0, serial_output_oe_n}, 16'h0000);
		word(32'h0000_0000, 16);
		chk("readback", host.rx[15:0], 16'h0456);
		chk("oe_n", {15'h0, serial_output_oe_n}, 16'h0001);
		word(32'h0000_a000, 16);
		state(12'h456, 1'b0, 1'b1);
		word(32'h0000_1321, 16);
		state(12'h321, 1'b0, 1'b1);
		do_reset();
		state(12'h000, 1'b1, 1'b0);
		word(32'h0000_1fff, 16);
		state(12'hfff, 1'b1, 1'b0);
		print_verdict();
	end

	// 21 frames of at most 6 us each, with wide margin
	initial begin
		#500000;
		errors++;
		print_verdict();
	end
endmodule
